//--- rtl/pbc_pkg.sv
package pbc_pkg;

  localparam int DATA_W             = 32;
  localparam int CBE_W              = 4;
  localparam int CMD_W              = 16;
  localparam int CMD_PERR_BIT       = 6;
  localparam int CMD_SERR_BIT       = 8;
  localparam int DEVSEL_TIMEOUT_CLK = 5;
  localparam int BUF_DEPTH          = 2;

  localparam logic [3:0] CMD_MEM_RD = 4'h6;
  localparam logic [3:0] CMD_MEM_WR = 4'h7;
  localparam logic [3:0] CMD_CFG_RD = 4'hA;
  localparam logic [3:0] CMD_CFG_WR = 4'hB;
  localparam logic [3:0] BE_ALL     = 4'h0;

  typedef enum logic [1:0] {
    I_IDLE = 2'b00,
    I_ADDR = 2'b01,
    I_DATA = 2'b10,
    I_TURN = 2'b11
  } pbc_ist_type;

  typedef enum logic [1:0] {
    T_IDLE = 2'b00,
    T_DATA = 2'b01,
    T_TURN = 2'b10
  } pbc_tst_type;

  typedef struct packed {
    logic [DATA_W-1:0] addr;
    logic [3:0]        cmd;
    logic [DATA_W-1:0] wdata;
  } pbc_mst_req_type;

  typedef struct packed {
    logic [DATA_W-1:0] rdata;
    logic              mabort;
    logic              tstop;
  } pbc_mst_rsp_type;

  typedef struct packed {
    logic [DATA_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic [CBE_W-1:0]  be_n;
    logic              cfg;
  } pbc_tgt_wr_type;

endpackage : pbc_pkg

//--- rtl/pbc_ctrl.sv
// Contract
// - As target the block drives device-select low to claim every cycle addressed to it.
// - As initiator the block watches device-select and ends with a master abort if nobody claims in time.
// - The initiator drives frame low to start a transaction and holds it while more data follows.
// - Frame high means the final data phase, and the next completed phase is the last.
// - The block asserts its bus request whenever it needs the bus as initiator.
// - Grant may arrive without a request because of parking, and the block must tolerate it.
// - Configuration accesses are answered only while the initialization select input is high.
// - A data phase completes only on an edge where initiator ready and target ready are both low.
// - The initiator drives initiator ready and the addressed target drives target ready.
// - Parity error is driven when received parity mismatches, only while command bit 6 is set.
// - System error is pulsed for a system error, even when not target, only while command bit 8 is set.
// - With system error enabled, a card-side address parity error also pulses system error.
// - A target may assert stop to end a transaction and the initiator must then terminate.
// - Even parity covers the 32 data lines and 4 command lines and is driven one clock after them.
`timescale 1ns/1ps
module pbc_ctrl import pbc_pkg::*; #(
  parameter logic [DATA_W-1:0] MEM_BASE     = 32'h8000_0000,
  parameter int                MEM_ADDR_LSB = 12,
  parameter int                BUF_W        = $bits(pbc_tgt_wr_type)
) (
  input  wire logic                  ref_clk_i,       // Bus clock
  input  wire logic                  reset_n_i,       // Sync reset
  input  wire logic [CMD_W-1:0]      cmd_reg_i,       // Command register
  input  wire logic                  idsel_i,         // Config select
  input  wire logic                  gnt_n_i,         // Bus grant
  output logic                       req_n_o,         // Bus request
  input  wire logic [DATA_W-1:0]     ad_i,            // Address/data in
  output logic [DATA_W-1:0]          ad_o,            // Address/data out
  output logic                       ad_oe_o,         // Address/data enable
  input  wire logic [CBE_W-1:0]      cbe_n_i,         // Command/enables in
  output logic [CBE_W-1:0]           cbe_n_o,         // Command/enables out
  output logic                       cbe_oe_o,        // Command enable
  input  wire logic                  par_i,           // Parity in
  output logic                       par_o,           // Parity out
  output logic                       par_oe_o,        // Parity enable
  input  wire logic                  frame_n_i,       // Frame in
  output logic                       frame_n_o,       // Frame out
  output logic                       frame_oe_o,      // Frame enable
  input  wire logic                  irdy_n_i,        // Initiator ready in
  output logic                       irdy_n_o,        // Initiator ready out
  output logic                       irdy_oe_o,       // Initiator ready enable
  input  wire logic                  trdy_n_i,        // Target ready in
  output logic                       trdy_n_o,        // Target ready out
  output logic                       trdy_oe_o,       // Target ready enable
  input  wire logic                  stop_n_i,        // Stop in
  output logic                       stop_n_o,        // Stop out
  output logic                       stop_oe_o,       // Stop enable
  input  wire logic                  devsel_n_i,      // Device select in
  output logic                       devsel_n_o,      // Device select out
  output logic                       devsel_oe_o,     // Device select enable
  input  wire logic                  perr_n_i,        // Parity error in
  output logic                       perr_n_o,        // Parity error out
  output logic                       perr_oe_o,       // Parity error enable
  output logic                       serr_n_o,        // System error out
  output logic                       serr_oe_o,       // System error enable
  input  wire logic                  sys_err_i,       // Internal error event
  input  wire logic                  cb_addr_perr_i,  // Card address parity event
  input  wire logic                  mst_req_valid_i, // Initiator request valid
  output logic                       mst_req_ready_o, // Initiator request taken
  input  wire pbc_mst_req_type       mst_req_i,       // Initiator request
  output logic                       mst_done_o,      // Initiator done pulse
  output pbc_mst_rsp_type            mst_rsp_o,       // Initiator result
  input  wire logic [DATA_W-1:0]     tgt_rd_data_i,   // Target read data
  output logic                       tgt_wr_valid_o,  // Target write valid
  input  wire logic                  tgt_wr_ready_i,  // Target write ready
  output pbc_tgt_wr_type             tgt_wr_o         // Target write word
);

  if (MEM_ADDR_LSB < 2 || MEM_ADDR_LSB > DATA_W - 1) begin : g_lsb_bad
    $error("MEM_ADDR_LSB out of range");
  end
  if (BUF_W != $bits(pbc_tgt_wr_type)) begin : g_buf_w_bad
    $error("BUF_W must match the write word");
  end

  pbc_ist_type       ist_reg, ist_next;
  pbc_tst_type       tst_reg, tst_next;
  pbc_mst_req_type   req_reg;
  pbc_mst_rsp_type   rsp_reg;
  logic              done_reg;
  logic [2:0]        to_cnt_reg;
  logic              frame_prev_reg;
  logic              t_wr_reg, t_cfg_reg, t_first_reg;
  logic [DATA_W-1:0] t_addr_reg, t_rdata_reg;
  logic              par_reg, par_oe_reg;
  logic              exp_par_reg, addr_chk_reg, data_chk_reg;
  logic              perr_low_reg, perr_high_reg, serr_reg;
  logic [BUF_W-1:0]  buf_mem_reg [BUF_DEPTH];
  logic              buf_wp_reg, buf_rp_reg;
  logic [1:0]        buf_cnt_reg;

  // Decode
  wire       perr_en     = cmd_reg_i[CMD_PERR_BIT];
  wire       serr_en     = cmd_reg_i[CMD_SERR_BIT];
  wire       bus_par     = ^{ad_i, cbe_n_i};
  wire       addr_phase  = !frame_n_i && frame_prev_reg;
  wire [3:0] bus_cmd     = ~cbe_n_i;
  wire       cmd_cfg     = (bus_cmd == CMD_CFG_RD) || (bus_cmd == CMD_CFG_WR);
  wire       cmd_mem     = (bus_cmd == CMD_MEM_RD) || (bus_cmd == CMD_MEM_WR);
  wire       mem_hit     = ad_i[DATA_W-1:MEM_ADDR_LSB] == MEM_BASE[DATA_W-1:MEM_ADDR_LSB];
  wire       cfg_hit     = cmd_cfg && idsel_i;
  wire       tgt_hit     = addr_phase && (ist_reg == I_IDLE) && (cfg_hit || (cmd_mem && mem_hit));
  wire       buf_in_rdy  = buf_cnt_reg != 2'(BUF_DEPTH);
  wire       t_ready     = t_wr_reg ? buf_in_rdy : !t_first_reg;
  wire       t_xfer      = (tst_reg == T_DATA) && !irdy_n_i && t_ready;
  wire       t_abort     = (tst_reg == T_DATA) && frame_n_i && irdy_n_i;
  wire       bus_idle    = frame_n_i && irdy_n_i;
  wire       i_start     = (ist_reg == I_IDLE) && mst_req_valid_i && !gnt_n_i && bus_idle;
  wire       i_write     = req_reg.cmd[0];
  wire       i_xfer      = (ist_reg == I_DATA) && !trdy_n_i;
  wire       i_stop      = (ist_reg == I_DATA) && !stop_n_i && trdy_n_i;
  wire       i_timeout   = (ist_reg == I_DATA) && devsel_n_i && (to_cnt_reg == 3'(DEVSEL_TIMEOUT_CLK));
  wire       par_bad     = par_i != exp_par_reg;
  wire       buf_push    = t_xfer && t_wr_reg;
  wire       buf_pop     = tgt_wr_valid_o && tgt_wr_ready_i;

  // Initiator sequencing
  always_comb begin
    ist_next = ist_reg;
    case (ist_reg)
      I_IDLE:  if (i_start) ist_next = I_ADDR;
      I_ADDR:  ist_next = I_DATA;
      I_DATA:  if (i_xfer || i_stop || i_timeout) ist_next = I_TURN;
      I_TURN:  ist_next = I_IDLE;
      default: ist_next = I_IDLE;
    endcase
  end

  // Target sequencing
  always_comb begin
    tst_next = tst_reg;
    case (tst_reg)
      T_IDLE:  if (tgt_hit) tst_next = T_DATA;
      T_DATA:  if (t_xfer || t_abort) tst_next = T_TURN;
      T_TURN:  tst_next = T_IDLE;
      default: tst_next = T_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      ist_reg        <= I_IDLE;
      tst_reg        <= T_IDLE;
      frame_prev_reg <= 1'b1;
      to_cnt_reg     <= 3'h0;
    end else begin
      ist_reg        <= ist_next;
      tst_reg        <= tst_next;
      frame_prev_reg <= frame_n_i;
      to_cnt_reg     <= (ist_reg == I_IDLE) ? 3'h1 : to_cnt_reg + ((to_cnt_reg != 3'h7) ? 3'h1 : 3'h0);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      req_reg  <= '0;
      rsp_reg  <= '0;
      done_reg <= 1'b0;
    end else begin
      if (i_start) req_reg <= mst_req_i;
      done_reg <= i_xfer || i_stop || i_timeout;
      if (i_xfer || i_stop || i_timeout) begin
        rsp_reg.rdata  <= i_write ? '0 : ad_i;
        rsp_reg.mabort <= i_timeout && !i_xfer;
        rsp_reg.tstop  <= i_stop;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      t_wr_reg    <= 1'b0;
      t_cfg_reg   <= 1'b0;
      t_first_reg <= 1'b0;
      t_addr_reg  <= '0;
      t_rdata_reg <= '0;
    end else begin
      t_first_reg <= tgt_hit;
      if (tgt_hit) begin
        t_wr_reg   <= bus_cmd[0];
        t_cfg_reg  <= cmd_cfg;
        t_addr_reg <= ad_i;
      end
      if (tst_reg == T_DATA) t_rdata_reg <= tgt_rd_data_i;
    end
  end

  // Parity generate and check
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      par_reg       <= 1'b0;
      par_oe_reg    <= 1'b0;
      exp_par_reg   <= 1'b0;
      addr_chk_reg  <= 1'b0;
      data_chk_reg  <= 1'b0;
      perr_low_reg  <= 1'b0;
      perr_high_reg <= 1'b0;
      serr_reg      <= 1'b0;
    end else begin
      par_reg       <= bus_par;
      par_oe_reg    <= ad_oe_o;
      exp_par_reg   <= bus_par;
      addr_chk_reg  <= addr_phase;
      data_chk_reg  <= buf_push || (i_xfer && !i_write);
      perr_low_reg  <= data_chk_reg && par_bad && perr_en;
      perr_high_reg <= perr_low_reg;
      serr_reg      <= serr_en && ((addr_chk_reg && par_bad) || sys_err_i || cb_addr_perr_i);
    end
  end

  // Two-entry write buffer
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      buf_wp_reg  <= 1'b0;
      buf_rp_reg  <= 1'b0;
      buf_cnt_reg <= 2'h0;
    end else begin
      if (buf_push) buf_wp_reg <= !buf_wp_reg;
      if (buf_pop) buf_rp_reg <= !buf_rp_reg;
      buf_cnt_reg <= buf_cnt_reg + 2'(buf_push) - 2'(buf_pop);
    end
  end

  generate
    for (genvar e = 0; e < BUF_DEPTH; e++) begin : g_buf
      always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
          buf_mem_reg[e] <= '0;
        end else if (buf_push && (buf_wp_reg == 1'(e))) begin
          buf_mem_reg[e] <= {t_addr_reg, ad_i, cbe_n_i, t_cfg_reg};
        end
      end
    end
  endgenerate

  // Pin drive
  assign req_n_o         = !((ist_reg == I_IDLE) && mst_req_valid_i);
  assign mst_req_ready_o = i_start;
  assign frame_oe_o      = (ist_reg == I_ADDR) || (ist_reg == I_DATA);
  assign frame_n_o       = ist_reg != I_ADDR;
  assign irdy_oe_o       = (ist_reg == I_DATA) || (ist_reg == I_TURN);
  assign irdy_n_o        = ist_reg != I_DATA;
  assign cbe_oe_o        = (ist_reg == I_ADDR) || (ist_reg == I_DATA);
  assign cbe_n_o         = (ist_reg == I_ADDR) ? ~req_reg.cmd : BE_ALL;
  assign ad_oe_o         = (ist_reg == I_ADDR) || ((ist_reg == I_DATA) && i_write) ||
                           ((tst_reg == T_DATA) && !t_wr_reg && !t_first_reg);
  assign ad_o            = (ist_reg == I_ADDR) ? req_reg.addr :
                           (ist_reg == I_DATA) ? req_reg.wdata : t_rdata_reg;
  assign par_o           = par_reg;
  assign par_oe_o        = par_oe_reg;
  assign devsel_oe_o     = tst_reg != T_IDLE;
  assign devsel_n_o      = tst_reg != T_DATA;
  assign trdy_oe_o       = tst_reg != T_IDLE;
  assign trdy_n_o        = !((tst_reg == T_DATA) && t_ready);
  assign stop_oe_o       = tst_reg != T_IDLE;
  // Read turnaround waits without stop, so the disconnect carries data
  assign stop_n_o        = !((tst_reg == T_DATA) && (t_wr_reg || !t_first_reg));
  assign perr_oe_o       = perr_low_reg || perr_high_reg;
  assign perr_n_o        = !perr_low_reg;
  assign serr_oe_o       = serr_reg;
  assign serr_n_o        = !serr_reg;
  assign mst_done_o      = done_reg;
  assign mst_rsp_o       = rsp_reg;
  assign tgt_wr_valid_o  = buf_cnt_reg != 2'h0;
  assign tgt_wr_o        = buf_mem_reg[buf_rp_reg];

  property p_claim;
    @(posedge ref_clk_i) disable iff (!reset_n_i) tgt_hit |=> devsel_oe_o && !devsel_n_o;
  endproperty
  a_claim: assert property (p_claim) else $error("claim not driven");

  property p_mabort;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      (ist_reg == I_ADDR) ##1 (devsel_n_i && trdy_n_i && stop_n_i)[*4] |=> mst_done_o && mst_rsp_o.mabort;
  endproperty
  a_mabort: assert property (p_mabort) else $error("no master abort");

  property p_frame;
    @(posedge ref_clk_i) disable iff (!reset_n_i) i_start |=> frame_oe_o && !frame_n_o ##1 frame_n_o && !irdy_n_o;
  endproperty
  a_frame: assert property (p_frame) else $error("frame sequence wrong");

  property p_req;
    @(posedge ref_clk_i) disable iff (!reset_n_i) (ist_reg == I_IDLE && mst_req_valid_i) |-> !req_n_o;
  endproperty
  a_req: assert property (p_req) else $error("request not raised");

  property p_park;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      (ist_reg == I_IDLE && !gnt_n_i && !mst_req_valid_i) |=> !frame_oe_o;
  endproperty
  a_park: assert property (p_park) else $error("parked grant started a cycle");

  property p_cfg;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      (addr_phase && cmd_cfg && !idsel_i && tst_reg == T_IDLE) |=> !devsel_oe_o;
  endproperty
  a_cfg: assert property (p_cfg) else $error("config claimed without select");

  property p_xfer;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      (tst_reg == T_DATA && !trdy_n_o && !irdy_n_i) |=> tst_reg == T_TURN && trdy_n_o;
  endproperty
  a_xfer: assert property (p_xfer) else $error("data phase not completed");

  property p_perr;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      (data_chk_reg && par_bad && perr_en) |=> !perr_n_o && perr_oe_o ##1 perr_n_o && perr_oe_o;
  endproperty
  a_perr: assert property (p_perr) else $error("parity error not reported");

  property p_serr;
    @(posedge ref_clk_i) disable iff (!reset_n_i) !serr_n_o |-> $past(serr_en) && serr_oe_o;
  endproperty
  a_serr: assert property (p_serr) else $error("system error while disabled");

  property p_stop;
    @(posedge ref_clk_i) disable iff (!reset_n_i) i_stop |=> ist_reg == I_TURN ##1 !irdy_oe_o;
  endproperty
  a_stop: assert property (p_stop) else $error("stop not honoured");

  property p_par;
    @(posedge ref_clk_i) disable iff (!reset_n_i) par_oe_o |-> par_o == $past(bus_par) && $past(ad_oe_o);
  endproperty
  a_par: assert property (p_par) else $error("parity not one clock late");

endmodule : pbc_ctrl

//--- verif/pbc_bus_model.sv
`timescale 1ns/1ps
module pbc_bus_model import pbc_pkg::*; (
  input  wire logic              ref_clk_i,  // Bus clock
  input  wire logic              req_n_o,    // Block request
  input  wire logic              frame_oe_o, // Block owns frame
  input  wire logic              frame_n_i,  // Bus frame
  input  wire logic              irdy_n_i,   // Bus irdy
  input  wire logic              trdy_n_i,   // Bus trdy
  input  wire logic              stop_n_i,   // Bus stop
  input  wire logic              devsel_n_i, // Bus devsel
  input  wire logic [DATA_W-1:0] ad_i,       // Bus data
  input  wire logic [CBE_W-1:0]  cbe_n_i,    // Bus command
  input  wire logic [1:0]        mode_i,     // Answer kind
  input  wire logic              park_i,     // Parked grant
  input  wire logic [DATA_W-1:0] rdv_i,      // Read data
  output logic                   gnt_n_i,    // Grant
  output logic [4:0]             m_ctl_n_o,  // Frame irdy trdy stop devsel
  output logic [DATA_W-1:0]      m_ad_o,     // Data out
  output logic                   m_ad_oe_o,  // Data enable
  output logic [CBE_W-1:0]       m_cbe_n_o,  // Command out
  output logic                   m_cbe_oe_o, // Command enable
  output logic                   m_par_o     // Parity out
);
  logic rd;
  int   n;

  always @(negedge ref_clk_i) gnt_n_i <= !(!req_n_o || park_i);

  // Target for cycles the block starts; mode 3 never claims
  initial begin
    {m_ctl_n_o, m_ad_oe_o, m_cbe_oe_o, m_par_o} = 8'hF8;
    m_ad_o = '0;
    m_cbe_n_o = '1;
    forever begin
      @(posedge ref_clk_i);
      if (frame_n_i === 1'b0 && frame_oe_o === 1'b1) begin
        rd = cbe_n_i[0];
        @(negedge ref_clk_i);
        m_ctl_n_o[0] = (mode_i == 2'd3);
        if (mode_i != 2'd3) begin
          if (mode_i == 2'd1) repeat (2) @(negedge ref_clk_i);
          m_ctl_n_o[2:1] = {mode_i == 2'd2, mode_i != 2'd2};
          m_ad_oe_o = rd && mode_i != 2'd2;
          m_ad_o = rdv_i;
          n = 0;
          do begin
            @(posedge ref_clk_i);
            n++;
          end while ((irdy_n_i || (trdy_n_i && stop_n_i)) && n < 9);
          @(negedge ref_clk_i);
          m_par_o = ^{rdv_i, 4'h0};
          m_ctl_n_o[2:0] = 3'b111;
          m_ad_oe_o = 1'b0;
        end
      end
    end
  end

  task automatic init_cyc(input logic [31:0] a, input logic [3:0] c, input logic [31:0] d,
                          input logic bad, output logic dv, output logic got, output logic [31:0] rd_o);
    int k;
    @(negedge ref_clk_i);
    m_ctl_n_o[4] = 1'b0;
    {m_ad_oe_o, m_cbe_oe_o, m_ad_o, m_cbe_n_o} = {2'b11, a, ~c};
    @(negedge ref_clk_i);
    m_ctl_n_o[4:3] = 2'b10;
    {m_ad_oe_o, m_ad_o, m_cbe_n_o, m_par_o} = {c[0], d, 4'h0, ^{a, ~c}};
    dv = 1'b0;
    k = 0;
    do begin
      @(posedge ref_clk_i);
      dv |= !devsel_n_i;
      got = !trdy_n_i;
      rd_o = ad_i;
      k++;
    end while (!got && stop_n_i && k < 8);
    @(negedge ref_clk_i);
    m_ctl_n_o[3] = 1'b1;
    {m_ad_oe_o, m_cbe_oe_o, m_par_o} = {2'b00, ^{d, 4'h0} ^ bad};
  endtask : init_cyc
endmodule : pbc_bus_model

//--- verif/pbc_ctrl_test.sv
`timescale 1ns/1ps
module pbc_ctrl_test import pbc_pkg::*;;
  localparam logic [DATA_W-1:0] MBASE = 32'h8000_0000;
  logic ref_clk_i = 1'b0;
  logic reset_n_i, idsel_i, gnt_n_i, req_n_o, ad_oe_o, cbe_oe_o, par_i, par_o, par_oe_o;
  logic frame_n_i, frame_n_o, frame_oe_o, irdy_n_i, irdy_n_o, irdy_oe_o;
  logic trdy_n_i, trdy_n_o, trdy_oe_o, stop_n_i, stop_n_o, stop_oe_o;
  logic devsel_n_i, devsel_n_o, devsel_oe_o, perr_n_i, perr_n_o, perr_oe_o;
  logic serr_n_o, serr_oe_o, sys_err_i, cb_addr_perr_i, mst_req_valid_i, mst_req_ready_o;
  logic mst_done_o, tgt_wr_valid_o, tgt_wr_ready_i, park_i, m_ad_oe_o, m_cbe_oe_o, m_par_o;
  logic [DATA_W-1:0] ad_i, ad_o, tgt_rd_data_i, rdv_i, m_ad_o;
  logic [DATA_W-1:0] junk = 32'h5A5A_C3C3;
  logic [CBE_W-1:0]  cbe_n_i, cbe_n_o, m_cbe_n_o;
  logic [CMD_W-1:0]  cmd_reg_i;
  logic [4:0]        m_ctl_n_o;
  logic [1:0]        mode_i;
  logic [31:0]       seed = 32'h48;
  pbc_mst_req_type   mst_req_i;
  pbc_mst_rsp_type   mst_rsp_o;
  pbc_tgt_wr_type    tgt_wr_o;
  pbc_tgt_wr_type    exp_q[$];
  int                fails, num_checks, perr_cnt, serr_cnt;

  always #12.5 ref_clk_i = ~ref_clk_i;
  // Released data lines show a changing pattern
  always @(negedge ref_clk_i) junk <= ~junk;
  always @(posedge ref_clk_i) begin
    perr_cnt += (perr_oe_o === 1'b1 && perr_n_o === 1'b0);
    serr_cnt += (serr_oe_o === 1'b1 && serr_n_o === 1'b0);
  end

  assign frame_n_i  = frame_oe_o ? frame_n_o : m_ctl_n_o[4];
  assign irdy_n_i   = irdy_oe_o ? irdy_n_o : m_ctl_n_o[3];
  assign trdy_n_i   = trdy_oe_o ? trdy_n_o : m_ctl_n_o[2];
  assign stop_n_i   = stop_oe_o ? stop_n_o : m_ctl_n_o[1];
  assign devsel_n_i = devsel_oe_o ? devsel_n_o : m_ctl_n_o[0];
  assign perr_n_i   = perr_oe_o ? perr_n_o : 1'b1;
  assign ad_i       = ad_oe_o ? ad_o : (m_ad_oe_o ? m_ad_o : junk);
  assign cbe_n_i    = cbe_oe_o ? cbe_n_o : (m_cbe_oe_o ? m_cbe_n_o : junk[3:0]);
  assign par_i      = par_oe_o ? par_o : m_par_o;

  pbc_ctrl #(.MEM_BASE(MBASE)) pbc_ctrl_i (.*);
  pbc_bus_model pbc_bus_model_i (.*);

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  task automatic chk(input logic [127:0] seen, input logic [127:0] want);
    num_checks++;
    if (seen !== want) begin
      fails++;
      $display("unexpected at %0t: saw %0h, expected %0h", $time, seen, want);
    end
  endtask : chk

  task automatic finish_test();
    $display("checks %0d, mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : finish_test

  task automatic mst(input logic [3:0] c, input logic [1:0] m);
    int n, fl, il;
    logic pa;
    mode_i = m;
    rdv_i = xs();
    mst_req_i = '{xs(), c, xs()};
    mst_req_valid_i = 1'b1;
    #1 chk(req_n_o, 1'b0);
    n = 0;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (mst_req_ready_o !== 1'b1 && n < 20);
    @(negedge ref_clk_i);
    mst_req_valid_i = 1'b0;
    n = 1;
    fl = 0;
    il = 0;
    while (mst_done_o !== 1'b1 && n < 12) begin
      if (frame_n_i === 1'b0) begin
        fl++;
        pa = ^{ad_i, cbe_n_i};
      end else if (fl == 1 && il == 0) begin
        chk(par_i, pa);
      end
      il += (irdy_n_i === 1'b0);
      @(negedge ref_clk_i);
      n++;
    end
    chk(n >= 3 && n <= 7, 1'b1);
    chk({mst_rsp_o.mabort, mst_rsp_o.tstop}, {m == 2'd3, m == 2'd2});
    chk(fl, 1);
    if (m != 2'd3) chk(il, m == 2'd1 ? 3 : 1);
    if (!c[0] && m < 2'd2) chk(mst_rsp_o.rdata, rdv_i);
    @(negedge ref_clk_i);
  endtask : mst

  task automatic tgt(input logic [3:0] c, input logic id, input logic hit, input logic bad,
                     input logic [1:0] want);
    logic dv, got;
    logic [DATA_W-1:0] a, d, rd;
    a = xs();
    d = xs();
    if (!c[3]) a = hit ? {MBASE[31:12], a[11:0]} : {1'b0, a[30:0]};
    tgt_rd_data_i = xs();
    idsel_i = id;
    pbc_bus_model_i.init_cyc(a, c, d, bad, dv, got, rd);
    idsel_i = 1'b0;
    chk({dv, got}, want);
    if (got && c[0]) exp_q.push_back('{a, d, 4'h0, c[3]});
    if (got && !c[0]) chk(rd, tgt_rd_data_i);
  endtask : tgt

  task automatic drain();
    tgt_wr_ready_i = 1'b1;
    repeat (5) begin
      @(posedge ref_clk_i);
      if (tgt_wr_valid_o === 1'b1) chk(tgt_wr_o, exp_q.pop_front());
    end
    @(negedge ref_clk_i);
    tgt_wr_ready_i = 1'b0;
    chk({tgt_wr_valid_o, exp_q.size()}, 33'h0);
  endtask : drain

  initial begin
    {reset_n_i, idsel_i, sys_err_i, cb_addr_perr_i, mst_req_valid_i, tgt_wr_ready_i, park_i} = '0;
    {cmd_reg_i, tgt_rd_data_i, rdv_i, mode_i} = '0;
    mst_req_i = '0;
    repeat (16) @(negedge ref_clk_i);
    chk({ad_oe_o, frame_oe_o, devsel_oe_o, serr_oe_o, mst_done_o, tgt_wr_valid_o, req_n_o}, 7'h01);
    reset_n_i = 1'b1;
    park_i = 1'b1;
    repeat (6) begin
      @(negedge ref_clk_i);
      chk({ad_oe_o, frame_oe_o, req_n_o}, 3'h1);
    end
    park_i = 1'b0;
    for (int m = 0; m < 4; m++) begin
      mst(CMD_MEM_RD, m[1:0]);
      mst(CMD_MEM_WR, m[1:0]);
    end
    tgt(CMD_CFG_WR, 1'b1, 1'b1, 1'b0, 2'b11);
    tgt(CMD_CFG_WR, 1'b0, 1'b1, 1'b0, 2'b00);
    tgt(CMD_MEM_WR, 1'b0, 1'b0, 1'b0, 2'b00);
    tgt(CMD_MEM_WR, 1'b0, 1'b1, 1'b0, 2'b11);
    tgt(CMD_MEM_WR, 1'b0, 1'b1, 1'b0, 2'b10);
    drain();
    tgt(CMD_CFG_RD, 1'b1, 1'b1, 1'b0, 2'b11);
    tgt(CMD_MEM_RD, 1'b0, 1'b1, 1'b0, 2'b11);
    for (int e = 0; e < 2; e++) begin
      cmd_reg_i = e ? 16'h0040 : 16'h0000;
      perr_cnt = 0;
      tgt(CMD_MEM_WR, 1'b0, 1'b1, 1'b1, 2'b11);
      repeat (4) @(negedge ref_clk_i);
      chk(perr_cnt, e);
      drain();
      cmd_reg_i = e ? 16'h0100 : 16'h0000;
      for (int s = 0; s < 2; s++) begin
        serr_cnt = 0;
        {cb_addr_perr_i, sys_err_i} = s ? 2'b10 : 2'b01;
        @(negedge ref_clk_i);
        {cb_addr_perr_i, sys_err_i} = 2'b00;
        repeat (4) @(negedge ref_clk_i);
        chk(serr_cnt, e);
      end
    end
    finish_test();
  end

  // Full run needs well under a thousand cycles
  initial begin
    #100000;
    fails++;
    finish_test();
  end
endmodule : pbc_ctrl_test
